// [core/tmrc_counter.sv]
// sixteen-bit counter with overflow flag, wide-access buffer, ahb slave
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module tmrc_counter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic aux_clk_in,
  input wire logic power_managed,
  output logic aux_osc_enable,
  output logic irq,
  output logic ovf_irq_req
);

  tmrc_pkg::tmrc_state_t s_q;
  tmrc_pkg::tmrc_state_t s_d;

  // =========================================================
  // helpers
  function automatic logic [31:0] tmrc_rd(
    input tmrc_pkg::tmrc_state_t st,
    input logic [7:0] a
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == tmrc_pkg::IDX_COUNT_LOW) begin
      v[7:0] = st.count[7:0];
    end else if (a == tmrc_pkg::IDX_COUNT_HIGH) begin
      // wide mode reads buffer, otherwise live byte
      if (st.control[tmrc_pkg::CTL_WIDE_BIT]) begin
        v[7:0] = st.high_buf;
      end else begin
        v[7:0] = st.count[15:8];
      end
    end else if (a == tmrc_pkg::IDX_CONTROL) begin
      v[7:0] = st.control;
      v[tmrc_pkg::CTL_RUN_STAT_BIT] = st.run_stat;
    end else if (a == tmrc_pkg::IDX_FLAG) begin
      v[tmrc_pkg::FLAG_OVF_BIT] = st.overflow_flag;
    end else if (a == tmrc_pkg::IDX_ENABLE) begin
      v[tmrc_pkg::FLAG_OVF_BIT] = st.overflow_irq_enable;
    end else if (a == tmrc_pkg::IDX_IRQ_STATUS) begin
      v[0] = st.irq_status;
    end else if (a == tmrc_pkg::IDX_IRQ_MASK) begin
      v[0] = st.irq_mask;
    end else if (a == tmrc_pkg::IDX_CLK_CTRL) begin
      v[1:0] = st.clk_ctrl;
    end else begin
      v = 32'h0000_0000;
    end
    return v;
  endfunction : tmrc_rd

  // =========================================================
  // next state
  always_comb begin
    logic tick;
    logic wrap;
    logic wr;
    logic rd;
    logic [7:0] wb;
    logic [2:0] pre_next;
    logic pre_done;
    logic [7:0] a;
    tick = 1'b0;
    wrap = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    wb = hwdata[7:0];
    pre_next = 3'h0;
    pre_done = 1'b0;
    a = s_q.req.addr;
    s_d = s_q;

    // aux clock input synchroniser and edge detect
    s_d.aux_sync1 = aux_clk_in;
    s_d.aux_sync2 = s_q.aux_sync1;
    s_d.aux_prev = s_q.aux_sync2;

    // address phase capture
    s_d.req.sel = hsel && hready && (htrans == tmrc_pkg::HTRANS_NONSEQ);
    s_d.req.write = hwrite;
    s_d.req.addr = {haddr[9:2]};
    wr = s_q.req.sel && s_q.req.write;
    rd = hsel && hready && (htrans == tmrc_pkg::HTRANS_NONSEQ) && !hwrite;

    // read data for next data phase
    s_d.rdata = 32'h0000_0000;
    if (rd) begin
      s_d.rdata = tmrc_rd(s_q, haddr[9:2]);
    end

    // count tick from selected source through prescaler
    if (s_q.control[tmrc_pkg::CTL_ON_BIT]) begin
      if (s_q.clk_ctrl[tmrc_pkg::CLKC_SRC_BIT] == tmrc_pkg::TMRC_SRC_AUX) begin
        tick = s_q.aux_sync2 && !s_q.aux_prev;
      end else begin
        tick = 1'b1;
      end
    end
    if (tick) begin
      pre_next = s_q.prescale + 3'h1;
      case (s_q.control[tmrc_pkg::CTL_PRE_LSB +: 2])
        2'h0: pre_done = 1'b1;
        2'h1: pre_done = (s_q.prescale[0] == 1'b1);
        2'h2: pre_done = (s_q.prescale[1:0] == 2'h3);
        default: pre_done = (s_q.prescale == 3'h7);
      endcase
      s_d.prescale = pre_done ? tmrc_pkg::PRE_RESET : pre_next;
      if (pre_done) begin
        s_d.count = s_q.count + 16'h0001;
        wrap = (s_q.count == tmrc_pkg::COUNT_MAX);
      end
    end

    // in wide mode, low byte read latches live high byte into buffer
    if (rd && haddr[9:2] == tmrc_pkg::IDX_COUNT_LOW &&
        s_q.control[tmrc_pkg::CTL_WIDE_BIT]) begin
      s_d.high_buf = s_q.count[15:8];
    end
    // reading the interrupt status clears it
    if (rd && haddr[9:2] == tmrc_pkg::IDX_IRQ_STATUS) begin
      s_d.irq_status = 1'b0;
    end

    // register writes
    if (wr) begin
      if (a == tmrc_pkg::IDX_COUNT_LOW) begin
        s_d.count[7:0] = wb;
        s_d.prescale = tmrc_pkg::PRE_RESET;
        if (s_q.control[tmrc_pkg::CTL_WIDE_BIT]) begin
          s_d.count[15:8] = s_q.high_buf;
        end
      end else if (a == tmrc_pkg::IDX_COUNT_HIGH) begin
        // prescaler untouched here
        if (s_q.control[tmrc_pkg::CTL_WIDE_BIT]) begin
          s_d.high_buf = wb;
        end else begin
          s_d.count[15:8] = wb;
        end
      end else if (a == tmrc_pkg::IDX_CONTROL) begin
        s_d.control = wb;
        s_d.control[tmrc_pkg::CTL_RUN_STAT_BIT] = 1'b0;
      end else if (a == tmrc_pkg::IDX_FLAG) begin
        s_d.overflow_flag = wb[tmrc_pkg::FLAG_OVF_BIT];
      end else if (a == tmrc_pkg::IDX_ENABLE) begin
        s_d.overflow_irq_enable = wb[tmrc_pkg::FLAG_OVF_BIT];
      end else if (a == tmrc_pkg::IDX_IRQ_MASK) begin
        s_d.irq_mask = wb[0];
      end else if (a == tmrc_pkg::IDX_CLK_CTRL) begin
        s_d.clk_ctrl = wb[1:0];
      end
    end

    // overflow sets win over any clear in the same cycle
    if (wrap) begin
      s_d.overflow_flag = 1'b1;
      s_d.irq_status = 1'b1;
    end

    // outputs
    s_d.osc_en_out = s_d.control[tmrc_pkg::CTL_OSC_EN_BIT];
    // power_managed deliberately has no effect on the oscillator
    s_d.osc_en_out = s_d.osc_en_out | (power_managed & 1'b0);
    s_d.run_stat = s_d.osc_en_out &&
        s_d.clk_ctrl[tmrc_pkg::CLKC_SYS_AUX_BIT];
    s_d.irq = s_d.irq_status && s_d.irq_mask;
  end

  // =========================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // outputs, registered except hreadyout and hresp, which are tied to constants
  logic ovf_req_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_req_q <= 1'b0;
    end else begin
      ovf_req_q <= s_d.overflow_flag && s_d.overflow_irq_enable;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign aux_osc_enable = s_q.osc_en_out;
  assign irq = s_q.irq;
  assign ovf_irq_req = ovf_req_q;

endmodule : tmrc_counter

`default_nettype wire

// [core/tmrc_pkg.sv]
// package for the sixteen-bit counter block: offsets, fields, types
package tmrc_pkg;

  // =========================================================
  // register word indices matched against haddr[9:2] (printed offsets not multiples of 4)
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h0F;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h0E;
  localparam logic [7:0] IDX_CONTROL = 8'h0D;
  localparam logic [7:0] IDX_FLAG = 8'h1E;
  localparam logic [7:0] IDX_ENABLE = 8'h1D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h22;

  // =========================================================
  // field positions
  localparam int CTL_WIDE_BIT = 7;
  localparam int CTL_RUN_STAT_BIT = 6;
  localparam int CTL_PRE_LSB = 4;
  localparam int CTL_OSC_EN_BIT = 3;
  localparam int CTL_ON_BIT = 0;
  localparam int FLAG_OVF_BIT = 0;
  localparam int CLKC_SRC_BIT = 0;
  localparam int CLKC_SYS_AUX_BIT = 1;

  // =========================================================
  // reset values, count limit and bus transfer code
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] PRE_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // =========================================================
  // types
  typedef enum logic [0:0] {
    TMRC_SRC_SYS = 1'b0,
    TMRC_SRC_AUX = 1'b1
  } tmrc_src_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } tmrc_req_t;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] high_buf;
    logic [7:0] control;
    logic [2:0] prescale;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] clk_ctrl;
    logic irq_status;
    logic irq_mask;
    logic aux_sync1;
    logic aux_sync2;
    logic aux_prev;
    tmrc_req_t req;
    logic [31:0] rdata;
    logic irq;
    logic osc_en_out;
    logic run_stat;
  } tmrc_state_t;

endpackage : tmrc_pkg

// [tb/timer1_sixteen_bit_counter_test.sv]
// self-checking bench for the sixteen-bit counter block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module timer1_sixteen_bit_counter_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic pm = 1'b0;
  logic aux_clk = 1'b0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic osc_en;
  wire logic irq;
  wire logic ovf;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  always #25 sys_clk = ~sys_clk;
  // slow free-running auxiliary clock, edges on sys_clk falling edges
  always #100 aux_clk = ~aux_clk;
  tmrc_counter uut (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(),
    .hrdata(hrdata), .aux_clk_in(aux_clk), .power_managed(pm),
    .aux_osc_enable(osc_en), .irq(irq), .ovf_irq_req(ovf));
  // =====================================
  // bus and report tasks
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge sys_clk); while (!hready && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    // data phase values as they stand at the falling edge before the closing edge
    do begin
      @(negedge sys_clk);
      rd = hrdata;
      ok = hready;
      @(posedge sys_clk);
    end while (!ok && ++n < 50);
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask : xfer
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask : rchk
  // =====================================
  // scenarios
  task automatic t_osc();
    rchk(8'h34, 8'h00);
    xfer(1'b1, 8'hF0, 8'h5A);
    rchk(8'hF0, 8'h00);
    xfer(1'b1, 8'h34, 8'h08);
    rchk(8'h34, 8'h08);
    `CHK(osc_en, 1'b1)
    pm <= 1'b1;
    rchk(8'h34, 8'h08);
    `CHK(osc_en, 1'b1)
    xfer(1'b1, 8'h88, 8'h02);
    rchk(8'h34, 8'h48);
    xfer(1'b1, 8'h88, 8'h00);
    xfer(1'b1, 8'h34, 8'h00);
    rchk(8'h34, 8'h00);
    `CHK(osc_en, 1'b0)
    $display("osc test done");
  endtask : t_osc
  task automatic t_wide();
    xfer(1'b1, 8'h3C, 8'h12);
    xfer(1'b1, 8'h38, 8'h34);
    rchk(8'h3C, 8'h12);
    xfer(1'b1, 8'h34, 8'h80);
    xfer(1'b1, 8'h3C, 8'hAB);
    rchk(8'h3C, 8'hAB);
    xfer(1'b1, 8'h34, 8'h00);
    rchk(8'h3C, 8'h12);
    xfer(1'b1, 8'h34, 8'h80);
    xfer(1'b1, 8'h38, 8'h56);
    xfer(1'b1, 8'h3C, 8'h00);
    rchk(8'h38, 8'h56);
    rchk(8'h3C, 8'hAB);
    xfer(1'b1, 8'h34, 8'h00);
    rchk(8'h3C, 8'hAB);
    $display("wide test done");
  endtask : t_wide
  task automatic t_wrap();
    int i;
    xfer(1'b1, 8'h3C, 8'hFF);
    xfer(1'b1, 8'h38, 8'hF0);
    xfer(1'b1, 8'h74, 8'h01);
    xfer(1'b1, 8'h84, 8'h01);
    xfer(1'b1, 8'h34, 8'h01);
    for (i = 0; i < 300 && ovf !== 1'b1; i++) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ovf, 1'b1)
    `CHK(irq, 1'b1)
    xfer(1'b1, 8'h34, 8'h00);
    rchk(8'h3C, 8'h00);
    xfer(1'b1, 8'h74, 8'h00);
    rchk(8'h78, 8'h01);
    `CHK(ovf, 1'b0)
    rchk(8'h80, 8'h01);
    rchk(8'h80, 8'h00);
    `CHK(irq, 1'b0)
    xfer(1'b1, 8'h78, 8'h00);
    rchk(8'h78, 8'h00);
    $display("wrap test done");
  endtask : t_wrap
  task automatic t_rtc();
    int i;
    // low byte is never written in this scenario
    xfer(1'b1, 8'h88, 8'h01);
    xfer(1'b1, 8'h74, 8'h01);
    xfer(1'b1, 8'h3C, 8'hFF);
    xfer(1'b1, 8'h34, 8'h09);
    for (i = 0; i < 2000 && ovf !== 1'b1; i++) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ovf, 1'b1)
    `CHK(osc_en, 1'b1)
    xfer(1'b1, 8'h3C, 8'h80);
    rchk(8'h3C, 8'h80);
    rchk(8'h78, 8'h01);
    xfer(1'b1, 8'h34, 8'h00);
    xfer(1'b1, 8'h88, 8'h00);
    xfer(1'b1, 8'h74, 8'h00);
    $display("rtc test done");
  endtask : t_rtc
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_osc();
    t_wide();
    t_wrap();
    t_rtc();
    give_verdict();
  end
endmodule : timer1_sixteen_bit_counter_test
`default_nettype wire

// [tb/tmrc_counter_chk.sv]
// assertion checker for the sixteen-bit counter block
`timescale 1ns/1ns
`default_nettype none
module tmrc_counter_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic aux_osc_enable,
  input wire logic irq,
  input wire logic ovf_irq_req
);
  logic wr_q;
  logic rd_q;
  logic [7:0] a_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // =====================================
  // data phase tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      a_q <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans == 2'h2 && hwrite;
      rd_q <= hsel && hready && htrans == 2'h2 && !hwrite;
      a_q <= haddr[7:0];
    end
  end
  sequence ctl_wr;
    wr_q && a_q == 8'h34;
  endsequence
  sequence en_wr;
    wr_q && a_q == 8'h74;
  endsequence
  // =====================================
  // assertions
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  osc_on_a: assert property (ctl_wr ##0 hwdata[3] |-> ##[1:2] aux_osc_enable)
    else $error("oscillator enable not set");
  osc_off_a: assert property (ctl_wr ##0 !hwdata[3] |-> ##[1:2] !aux_osc_enable)
    else $error("oscillator enable not cleared");
  osc_keep_a: assert property (aux_osc_enable && !wr_q && !$past(wr_q) |=> aux_osc_enable)
    else $error("oscillator stopped without write");
  irq_gate_a: assert property (en_wr ##0 !hwdata[0] |-> ##2 !ovf_irq_req)
    else $error("overflow request while disabled");
  flag_hold_a: assert property (ovf_irq_req && !wr_q && !$past(wr_q) |=> ovf_irq_req)
    else $error("overflow request dropped");
  flag_read_a: assert property (rd_q && a_q == 8'h78 && ovf_irq_req |-> hrdata[0])
    else $error("flag reads 0 while request high");
  unmapped_a: assert property (rd_q && a_q == 8'hF0 |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_clr_a: assert property (rd_q && a_q == 8'h80 |-> ##[1:3] !irq)
    else $error("interrupt not cleared by read");
endmodule : tmrc_counter_chk
bind tmrc_counter tmrc_counter_chk chk (.*);
`default_nettype wire
